// ==== shared/tccc_pkg.sv ====
// Functional notes
// - input select picks first, second, low, high
// - sync bit samples capture on timer clock
// - control bit 3 shows selected input level
// - output mode 0 follows output level bit
// - channel irq enable gates channel flag request
// - overflow bit sticky, cleared by writing zero
// - vector 16-bit read-only, code in bits 3:1
// - priority channel 1,2,3,4 then counter overflow
package tccc_pkg;
    localparam int NCH = 5;
    localparam int DW = 16;
    localparam int AW = 4;
    // register map, word addresses
    localparam logic [AW-1:0] ADDR_CTL0 = 4'h0;
    localparam logic [AW-1:0] ADDR_REG0 = 4'h5;
    localparam logic [AW-1:0] ADDR_VEC = 4'ha;
    localparam logic [AW-1:0] ADDR_OVF = 4'hb;
    localparam logic [AW-1:0] ADDR_IST = 4'hc;
    localparam logic [AW-1:0] ADDR_IMSK = 4'hd;
    localparam int NEV = NCH + 1;
    localparam logic [DW-1:0] CTL_WMASK = 16'hf9f7;
    localparam logic [DW-1:0] CTL_RST = 16'h0000;
    localparam logic [2:0] VEC_NONE = 3'h0;
    localparam logic [2:0] VEC_OVF = 3'h5;
    localparam logic [1:0] SEL_FIRST = 2'h0;
    localparam logic [1:0] SEL_SECOND = 2'h1;
    localparam logic [1:0] SEL_LOW = 2'h2;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    typedef struct packed {
        logic [1:0] capture_edge_select;
        logic [1:0] capture_input_select;
        logic sync_capture;
        logic latched_input_copy;
        logic unused9;
        logic capture_not_compare;
        logic [2:0] output_waveform_select;
        logic channel_irq_enable;
        logic input_level_view;
        logic out_level;
        logic capture_overflow;
        logic channel_irq_flag;
    } tccc_ctl_s;
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } tccc_bus_s;
endpackage : tccc_pkg

// ==== hw/tccc_top.sv ====
// Local design decisions: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module tccc_top (
    // clock, reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // register port
    input wire tccc_pkg::tccc_bus_s bus_i,
    output logic [tccc_pkg::DW-1:0] rdata_o,
    // timer side
    input wire logic [tccc_pkg::DW-1:0] count_i,
    input wire logic counter_overflow_i,
    input wire logic [tccc_pkg::NCH-1:0] compare_equal_signal_i,
    input wire logic [tccc_pkg::NCH-1:0] capture_input_first_i,
    input wire logic [tccc_pkg::NCH-1:0] capture_input_second_i,
    // outputs
    output logic [tccc_pkg::NCH-1:0] chan_out_o,
    output logic [tccc_pkg::NCH-1:0] chan_irq_o,
    output logic irq_o
);
    import tccc_pkg::*;

    tccc_ctl_s ctl_reg [NCH];
    logic [DW-1:0] ccr_reg [NCH];
    logic ovf_flag_reg;
    logic ovf_ie_reg;
    logic [NEV-1:0] ist_reg;
    logic [NEV-1:0] imsk_reg;
    logic [NCH-1:0] sync1_reg;
    logic [NCH-1:0] sync2_reg;
    logic [NCH-1:0] prev_reg;
    logic [NCH-1:0] sel_in;
    logic [NCH-1:0] cap_in;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] chan_pend;
    logic [2:0] vec_code;
    logic vec_rd;

    function automatic logic is_wr(input tccc_bus_s b, input logic [AW-1:0] a);
        return b.wr && (b.addr == a);
    endfunction : is_wr

    // register addresses of channel i
    function automatic logic [AW-1:0] ctl_addr(input int i);
        return AW'(ADDR_CTL0 + AW'(i));
    endfunction : ctl_addr

    function automatic logic [AW-1:0] ccr_addr(input int i);
        return AW'(ADDR_REG0 + AW'(i));
    endfunction : ccr_addr

    ////////////////////////////////////////////////////////////////////////
    // input selection and capture detection
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            unique case (ctl_reg[i].capture_input_select)
                SEL_FIRST: sel_in[i] = capture_input_first_i[i];
                SEL_SECOND: sel_in[i] = capture_input_second_i[i];
                SEL_LOW: sel_in[i] = 1'b0;
                default: sel_in[i] = 1'b1;
            endcase
            // async mode takes the raw pin, sync mode the resampled one
            cap_in[i] = ctl_reg[i].sync_capture ? sync2_reg[i] : sel_in[i];
            unique case (ctl_reg[i].capture_edge_select)
                EDGE_NONE: cap_ev[i] = 1'b0;
                EDGE_RISE: cap_ev[i] = cap_in[i] & ~prev_reg[i];
                EDGE_FALL: cap_ev[i] = ~cap_in[i] & prev_reg[i];
                default: cap_ev[i] = cap_in[i] ^ prev_reg[i];
            endcase
            cap_ev[i] = cap_ev[i] & ctl_reg[i].capture_not_compare;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
        end else begin
            sync1_reg <= sel_in;
            sync2_reg <= sync1_reg;
            prev_reg <= cap_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt vector
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            chan_pend[i] = ctl_reg[i].channel_irq_flag
                & ctl_reg[i].channel_irq_enable;
        end
    end

    always_comb begin
        vec_code = VEC_NONE;
        if (ovf_flag_reg && ovf_ie_reg) vec_code = VEC_OVF;
        for (int i = NCH - 1; i >= 1; i--) begin
            if (chan_pend[i]) vec_code = 3'(i);
        end
    end
    assign vec_rd = bus_i.rd && (bus_i.addr == ADDR_VEC);

    ////////////////////////////////////////////////////////////////////////
    // channel control and capture registers
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NCH; i++) begin
                ctl_reg[i] <= CTL_RST;
                ccr_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (is_wr(bus_i, ctl_addr(i))) begin
                    // read-only bits keep their state across a write
                    ctl_reg[i] <= (bus_i.wdata & CTL_WMASK)
                        | (ctl_reg[i] & ~CTL_WMASK);
                    // overflow clears only by writing zero
                    ctl_reg[i].capture_overflow <= ctl_reg[i].capture_overflow
                        & bus_i.wdata[1];
                end
                if (is_wr(bus_i, ccr_addr(i)))
                    ccr_reg[i] <= bus_i.wdata;
                if (vec_rd && vec_code == 3'(i) && i != 0)
                    ctl_reg[i].channel_irq_flag <= 1'b0;
                if (!ctl_reg[i].capture_not_compare && compare_equal_signal_i[i])
                    ctl_reg[i].channel_irq_flag <= 1'b1;
                if (cap_ev[i]) begin
                    ccr_reg[i] <= count_i;
                    ctl_reg[i].latched_input_copy <= cap_in[i];
                    ctl_reg[i].channel_irq_flag <= 1'b1;
                    if (ctl_reg[i].channel_irq_flag)
                        ctl_reg[i].capture_overflow <= 1'b1;
                end
                ctl_reg[i].input_level_view <= cap_in[i];
                ctl_reg[i].unused9 <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ovf_flag_reg <= 1'b0;
            ovf_ie_reg <= 1'b0;
        end else begin
            if (is_wr(bus_i, ADDR_OVF)) begin
                ovf_flag_reg <= bus_i.wdata[0];
                ovf_ie_reg <= bus_i.wdata[1];
            end else if (vec_rd && vec_code == VEC_OVF) begin
                ovf_flag_reg <= 1'b0;
            end
            if (counter_overflow_i) ovf_flag_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky event status and mask
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ist_reg <= '0;
            imsk_reg <= '0;
        end else begin
            if (is_wr(bus_i, ADDR_IMSK)) imsk_reg <= bus_i.wdata[NEV-1:0];
            // set wins over write-one-to-clear
            ist_reg <= (ist_reg & ~({NEV{is_wr(bus_i, ADDR_IST)}}
                & bus_i.wdata[NEV-1:0])) | {counter_overflow_i, cap_ev};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs and read data
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            chan_out_o <= '0;
            chan_irq_o <= '0;
            irq_o <= 1'b0;
            rdata_o <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                chan_out_o[i] <= ctl_reg[i].out_level;
                chan_irq_o[i] <= ctl_reg[i].channel_irq_flag
                    & ctl_reg[i].channel_irq_enable;
            end
            irq_o <= |(ist_reg & imsk_reg);
            rdata_o <= '0;
            if (bus_i.rd) begin
                for (int i = 0; i < NCH; i++) begin
                    if (bus_i.addr == ctl_addr(i))
                        rdata_o <= ctl_reg[i];
                    if (bus_i.addr == ccr_addr(i))
                        rdata_o <= ccr_reg[i];
                end
                unique case (bus_i.addr)
                    ADDR_VEC: rdata_o <= {12'h000, vec_code, 1'b0};
                    ADDR_OVF: rdata_o <= {14'h0000, ovf_ie_reg, ovf_flag_reg};
                    ADDR_IST: rdata_o <= {10'h000, ist_reg};
                    ADDR_IMSK: rdata_o <= {10'h000, imsk_reg};
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_vec_format: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $past(vec_rd) |-> rdata_o[15:4] == '0 && !rdata_o[0])
        else $error("vector reserved bits set");
    a_ovf_sticky: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ctl_reg[1].capture_overflow && !is_wr(bus_i, ADDR_CTL0 + 4'h1)
        |=> ctl_reg[1].capture_overflow)
        else $error("overflow cleared by itself");
    a_cap_copy: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        cap_ev[1] |=> ccr_reg[1] == $past(count_i)
        && ctl_reg[1].channel_irq_flag)
        else $error("capture did not copy count");
    a_out_follow: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ##1 chan_out_o[2] == $past(ctl_reg[2].out_level))
        else $error("output does not follow level");
    a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !ctl_reg[1].channel_irq_enable |=> !chan_irq_o[1])
        else $error("irq not gated");
    a_vec_prio: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ctl_reg[1].channel_irq_flag && ctl_reg[1].channel_irq_enable
        |-> vec_code == 3'h1)
        else $error("vector priority wrong");
    a_vec_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        vec_rd && vec_code == 3'h2 && !cap_ev[2] && !compare_equal_signal_i[2]
        |=> !ctl_reg[2].channel_irq_flag)
        else $error("vector read did not clear flag");
    a_level_view: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ##1 ctl_reg[0].input_level_view == $past(cap_in[0]))
        else $error("input level view stale");
    a_sel_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ctl_reg[3].capture_input_select == SEL_LOW |-> !sel_in[3])
        else $error("low select not low");
    a_sync_delay: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ##2 sync2_reg[0] == $past(sel_in[0], 2))
        else $error("sync chain wrong");
    a_ro_bit9: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !ctl_reg[0].unused9)
        else $error("bit 9 set");
    // per-channel routing and capture path
    a_sel_first: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ctl_reg[1].capture_input_select == SEL_FIRST
        |-> sel_in[1] == capture_input_first_i[1])
        else $error("first input not routed");
    a_sel_second: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ctl_reg[2].capture_input_select == SEL_SECOND
        |-> sel_in[2] == capture_input_second_i[2])
        else $error("second input not routed");
    a_sel_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        &ctl_reg[4].capture_input_select
        |-> sel_in[4])
        else $error("high select not high");
    a_sync_path: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ctl_reg[1].sync_capture
        |-> cap_in[1] == sync2_reg[1])
        else $error("sync capture not resampled");
    a_async_path: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !ctl_reg[1].sync_capture
        |-> cap_in[1] == sel_in[1])
        else $error("async capture not direct");
    a_ovf_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        cap_ev[2] && ctl_reg[2].channel_irq_flag
        |=> ctl_reg[2].capture_overflow)
        else $error("overflow not set");
    a_out_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !ctl_reg[4].out_level
        |=> !chan_out_o[4])
        else $error("output not low");
    // interrupt request and vector
    a_irq_pass: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        chan_pend[1]
        |=> chan_irq_o[1])
        else $error("enabled flag gives no request");
    a_vec_ovf: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ovf_flag_reg && ovf_ie_reg && !(|chan_pend[NCH-1:1])
        |-> vec_code == VEC_OVF)
        else $error("overflow not reported");
    a_vec_idle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !(ovf_flag_reg && ovf_ie_reg) && !(|chan_pend[NCH-1:1])
        |-> vec_code == VEC_NONE)
        else $error("vector reports idle source");
    a_vec_range: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        vec_code <= VEC_OVF)
        else $error("vector code reserved");
    a_ovf_drain: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        vec_rd && vec_code == VEC_OVF && !counter_overflow_i
        && !is_wr(bus_i, ADDR_OVF) |=> !ovf_flag_reg)
        else $error("vector read kept overflow");
    a_status_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        cap_ev[3]
        |=> ist_reg[3])
        else $error("status bit not set");
    a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        |(ist_reg & imsk_reg)
        |=> irq_o)
        else $error("level interrupt missing");
    c_capture: cover property (@(posedge clk_sys_i) cap_ev[1]);
    c_overflow: cover property (@(posedge clk_sys_i)
        cap_ev[1] && ctl_reg[1].channel_irq_flag);
    c_vec_read: cover property (@(posedge clk_sys_i) vec_rd && vec_code != 0);
    c_irq: cover property (@(posedge clk_sys_i) irq_o);
endmodule : tccc_top
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import tccc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    tccc_bus_s bus_i = '0;
    logic [DW-1:0] rdata_o;
    logic [DW-1:0] count_i = '0;
    logic [DW-1:0] d;
    logic [DW-1:0] w;
    logic counter_overflow_i = 1'b0;
    logic [NCH-1:0] eq_i = '0;
    logic [NCH-1:0] in_a = '0;
    logic [NCH-1:0] in_b = '0;
    logic [NCH-1:0] chan_out_o;
    logic [NCH-1:0] chan_irq_o;
    logic irq_o;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed = 76381;
    int ch;

    always #25 clk_sys_i = ~clk_sys_i;

    tccc_top uut (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .bus_i(bus_i),
        .rdata_o(rdata_o),
        .count_i(count_i),
        .counter_overflow_i(counter_overflow_i),
        .compare_equal_signal_i(eq_i),
        .capture_input_first_i(in_a),
        .capture_input_second_i(in_b),
        .chan_out_o(chan_out_o),
        .chan_irq_o(chan_irq_o),
        .irq_o(irq_o)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic lvl(input logic [1:0] s, input logic a, b);
        return s[1] ? s[0] : (s[0] ? b : a);
    endfunction : lvl

    task automatic finish_test;
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [DW-1:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one bus cycle, read data taken in the following cycle
    task automatic op(input logic [AW-1:0] a, input logic [DW-1:0] v,
                      input logic wr_en);
        @(posedge clk_sys_i);
        bus_i <= '{addr: a, wdata: v, wr: wr_en, rd: ~wr_en};
        @(posedge clk_sys_i);
        bus_i <= '0;
        #1;
        d = rdata_o;
    endtask : op

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e,
                      input string nm);
        op(a, '0, 1'b0);
        chk(nm, e, d);
    endtask : rd

    // rising then falling edge on first capture input of a channel
    task automatic edge_a(input int c);
        @(posedge clk_sys_i);
        in_a[c] <= 1'b1;
        @(posedge clk_sys_i);
        in_a[c] <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask : edge_a

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < NCH; i++) begin
            rd(AW'(i), 16'h0000, "ctl_reset");
        end
        rd(ADDR_VEC, 16'h0000, "vec_reset");
        op(4'hf, 16'hffff, 1'b1);
        rd(4'he, 16'h0000, "unmapped");
        for (int k = 0; k < 24; k++) begin
            ch = int'($unsigned($random(seed)) % NCH);
            w = 16'($random(seed)) & 16'h39f4;
            w = (k < 4) ? (w & 16'h09f4) | 16'(k << 12) : w;
            if (ch == 0) w[6] = 1'b0;
            @(posedge clk_sys_i);
            in_a <= NCH'($random(seed));
            in_b <= NCH'($random(seed));
            op(AW'(ch), w | 16'h0600, 1'b1);
            repeat (2) @(posedge clk_sys_i);
            rd(AW'(ch), w | {12'h0, lvl(w[13:12], in_a[ch], in_b[ch]), 3'h0},
               "ctl");
            chk("chan_out", {15'h0, w[2]}, {15'h0, chan_out_o[ch]});
        end
        @(posedge clk_sys_i);
        in_a <= '0;
        in_b <= '0;
        for (int i = 0; i < NCH; i++) begin
            op(AW'(i), 16'h0000, 1'b1);
        end
        // capture on rising edge, then overrun while flag pending
        w = 16'($random(seed));
        count_i <= w;
        op(4'h1, 16'h4110, 1'b1);
        edge_a(1);
        rd(4'h6, w, "capture");
        rd(4'h1, 16'h4511, "flag");
        chk("chan_irq", 16'h0001, {15'h0, chan_irq_o[1]});
        count_i <= ~w;
        edge_a(1);
        rd(4'h6, ~w, "recapture");
        rd(4'h1, 16'h4513, "overflow");
        repeat (4) @(posedge clk_sys_i);
        rd(4'h1, 16'h4513, "ovf_sticky");
        op(4'h1, 16'h4111, 1'b1);
        rd(4'h1, 16'h4511, "ovf_clear");
        op(4'h1, 16'h4101, 1'b1);
        repeat (2) @(posedge clk_sys_i);
        chk("chan_irq_off", 16'h0000, {15'h0, chan_irq_o[1]});
        // synchronised capture on channel 2
        op(4'h2, 16'h4910, 1'b1);
        edge_a(2);
        rd(4'h7, ~w, "sync_capture");
        rd(4'h2, 16'h4d11, "sync_flag");
        // status, mask and level interrupt
        op(ADDR_IMSK, 16'h0020, 1'b1);
        @(posedge clk_sys_i);
        counter_overflow_i <= 1'b1;
        @(posedge clk_sys_i);
        counter_overflow_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        chk("irq_set", 16'h0001, {15'h0, irq_o});
        op(ADDR_IMSK, 16'h0000, 1'b1);
        repeat (2) @(posedge clk_sys_i);
        chk("irq_masked", 16'h0000, {15'h0, irq_o});
        op(ADDR_IMSK, 16'h0020, 1'b1);
        op(ADDR_IST, 16'h0020, 1'b1);
        repeat (2) @(posedge clk_sys_i);
        chk("irq_clear", 16'h0000, {15'h0, irq_o});
        // all sources pending, vector drains in priority order
        for (int i = 0; i < NCH; i++) begin
            op(AW'(i), 16'h0010, 1'b1);
        end
        op(ADDR_OVF, 16'h0003, 1'b1);
        @(posedge clk_sys_i);
        eq_i <= '1;
        @(posedge clk_sys_i);
        eq_i <= '0;
        repeat (3) @(posedge clk_sys_i);
        for (int c = 1; c <= 6; c++) begin
            rd(ADDR_VEC, {12'h0, 3'(c % 6), 1'b0}, "vector");
        end
        rd(4'h1, 16'h0410, "vec_cleared");
        rd(4'h0, 16'h0011, "ch0_pending");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
